// ===== hw/fsps_sequencer.sv
// Flash self-programming sequencer top level.
// Operation
// - Control 00000001 then store loads buffer word.
// - Buffer clears on write end, re-enable, reset; a reset during a page write keeps it until the write ends.
// - EEPROM write discards loaded buffer data.
// - Control X0000101 then store writes selected page.
// - Section write keeps other readable, else halts.
// - Ready interrupt level while store enable clear.
// - Erase or write blocks section, sets busy.
// - Re-enable write clears section busy flag.
// - Control X0001001 then store sets boot locks.
// - Zero data bits 5..2 program boot locks.
// - Lock programming keeps whole flash readable.
// - EEPROM busy refuses programming and readback.
// - Lock read: pointer one, load within three.
// - Lock-set and enable clear after read or timeout.
// - Pointer zero fuse low, three fuse high.
// - Readback gives zero programmed, one unprogrammed.
// - Write in progress completes across reset.
// - Flash writes timed between 3.7 and 4.5 ms.
// - Other low five bit values have no effect.
// - Store enable stays set until operation ends.
// - Control bit layout with zero reset value.
// - Control X0000011 then store erases selected page.
`include "fsps_regs.svh"
module fsps_sequencer #(
   parameter int RWW_PAGES    = `FSPS_RWW_PAGES,
   parameter int WRITE_CYCLES = `FSPS_WRITE_MIN_CYC
) (
   input  wire logic                clk_in,
   input  wire logic                rstn_in,
   input  fsps_pkg::fsps_cpu_req_t  cpu_in,
   input  wire logic                ee_busy_in,
   input  fsps_pkg::fsps_nv_t       nv_in,
   input  wire logic [5:0]          pbuf_idx_in,
   output logic [7:0]               ctl_rdata_out,
   output logic                     lpm_hit_out,
   output logic [7:0]               lpm_data_out,
   output fsps_pkg::fsps_flash_cmd_t flash_cmd_out,
   output logic [15:0]              pbuf_data_out,
   output logic                     flash_busy_out,
   output logic                     rww_read_block_out,
   output logic                     cpu_halt_out,
   output logic                     irq_out
);
   localparam logic [6:0] RWW_LIMIT = 7'(RWW_PAGES);
   if (RWW_PAGES < 1 || RWW_PAGES > 127) begin : g_bad_rww
      $error("fsps_sequencer: RWW_PAGES out of range");
   end

   function automatic logic legal_cmd(input logic [4:0] c);
      legal_cmd = (c == `FSPS_CMD_LOAD) || (c == `FSPS_CMD_ERASE) ||
                  (c == `FSPS_CMD_WRITE) || (c == `FSPS_CMD_LOCK) ||
                  (c == `FSPS_CMD_REEN);
   endfunction

   // Fuse and lock inputs already carry zero for programmed bits, so they pass unchanged.
   function automatic logic [7:0] readback(input logic [1:0] z, input fsps_pkg::fsps_nv_t nv);
      case (z)
         `FSPS_Z_FUSE_LOW:  readback = nv.fuse_low;
         `FSPS_Z_LOCK:      readback = nv.lock;
         `FSPS_Z_FUSE_HIGH: readback = nv.fuse_high;
         default:           readback = `FSPS_NO_FUSE;
      endcase
   endfunction

   fsps_pkg::fsps_seq_st_t st_q;
   fsps_pkg::fsps_seq_st_t st_d;
   logic                   wt_busy;
   logic                   wt_done;
   fsps_pkg::fsps_op_e     wt_op;
   logic                   wt_rww;
   logic                   start_now;
   fsps_pkg::fsps_op_e     start_op;
   logic                   start_rww;
   logic                   arm_now;
   logic                   load_fire;
   logic                   lpm_fire;
   logic                   reen_fire;
   logic                   store_enable_bit_rd;
   logic [6:0]             zpage;
   logic [5:0]             zword;

   assign zpage = cpu_in.zptr[`FSPS_Z_PAGE_MSB:`FSPS_Z_PAGE_LSB];
   assign zword = cpu_in.zptr[`FSPS_Z_WORD_MSB:`FSPS_Z_WORD_LSB];

   always_comb begin
      start_now = 1'b0;
      start_op  = fsps_pkg::FSPS_OP_NONE;
      load_fire = 1'b0;
      reen_fire = 1'b0;
      lpm_fire  = 1'b0;
      if (st_q.state == fsps_pkg::FSPS_ST_ARMED && rstn_in && !ee_busy_in) begin
         if (cpu_in.spm) begin
            case (st_q.cmd)
               `FSPS_CMD_LOAD: load_fire = 1'b1;
               `FSPS_CMD_ERASE: begin
                  start_now = 1'b1;
                  start_op  = fsps_pkg::FSPS_OP_ERASE;
               end
               `FSPS_CMD_WRITE: begin
                  start_now = 1'b1;
                  start_op  = fsps_pkg::FSPS_OP_WRITE;
               end
               `FSPS_CMD_LOCK: begin
                  start_now = 1'b1;
                  start_op  = fsps_pkg::FSPS_OP_LOCK;
               end
               `FSPS_CMD_REEN: reen_fire = 1'b1;
               default: start_now = 1'b0;
            endcase
         end else if (cpu_in.lpm && st_q.cmd == `FSPS_CMD_LOCK &&
                      st_q.cnt >= `FSPS_LPM_LAST_CNT) begin
            lpm_fire = 1'b1;
         end
      end
   end

   // The lock command leaves no section busy, so the whole array stays readable.
   assign start_rww = (start_op != fsps_pkg::FSPS_OP_LOCK) && (zpage < RWW_LIMIT);
   assign arm_now = cpu_in.ctl_wr && rstn_in && !ee_busy_in && !wt_busy && !start_now &&
                    st_q.state != fsps_pkg::FSPS_ST_BUSY &&
                    legal_cmd(cpu_in.ctl_wdata[`FSPS_CTL_CMD_MSB:0]);

   always_comb begin
      st_d              = st_q;
      st_d.fcmd.valid   = 1'b0;
      st_d.lpm_hit      = 1'b0;
      st_d.pbuf_data    = st_q.loaded[pbuf_idx_in] ? st_q.words[pbuf_idx_in]
                                                   : `FSPS_ERASED_WORD;
      if (cpu_in.ctl_wr) begin
         st_d.irq_en = cpu_in.ctl_wdata[`FSPS_CTL_IRQEN];
      end
      case (st_q.state)
         fsps_pkg::FSPS_ST_ARMED: begin
            if (cpu_in.spm || lpm_fire || st_q.cnt == `FSPS_CNT_LAST) begin
               st_d.state = start_now ? fsps_pkg::FSPS_ST_BUSY : fsps_pkg::FSPS_ST_IDLE;
            end else begin
               st_d.cnt = st_q.cnt - 3'h1;
            end
         end
         fsps_pkg::FSPS_ST_BUSY: begin
            if (wt_done) begin
               st_d.state = fsps_pkg::FSPS_ST_IDLE;
            end
         end
         fsps_pkg::FSPS_ST_IDLE: st_d.state = fsps_pkg::FSPS_ST_IDLE;
         default:                st_d.state = fsps_pkg::FSPS_ST_IDLE;
      endcase
      if (arm_now) begin
         st_d.state = fsps_pkg::FSPS_ST_ARMED;
         st_d.cnt   = `FSPS_SPM_WINDOW;
         st_d.cmd   = cpu_in.ctl_wdata[`FSPS_CTL_CMD_MSB:0];
      end
      if (load_fire && !st_q.loaded[zword]) begin
         st_d.loaded[zword] = 1'b1;
         st_d.words[zword]  = {cpu_in.r1, cpu_in.r0};
      end
      if (load_fire || reen_fire) begin
         st_d.rww_busy = 1'b0;
      end
      if (start_now && start_rww) begin
         st_d.rww_busy = 1'b1;
      end
      if (start_now) begin
         st_d.fcmd.valid     = 1'b1;
         st_d.fcmd.op        = start_op;
         st_d.fcmd.page      = zpage;
         st_d.fcmd.lock_prog = ~cpu_in.r0[`FSPS_R0_BLB_MSB:`FSPS_R0_BLB_LSB];
      end
      if (lpm_fire) begin
         st_d.lpm_hit  = 1'b1;
         st_d.lpm_data = readback(cpu_in.zptr[1:0], nv_in);
      end
      if (reen_fire || ee_busy_in || (wt_done && wt_op == fsps_pkg::FSPS_OP_WRITE)) begin
         st_d.loaded = '0;
      end
      if (!rstn_in) begin
         st_d           = '0;
         st_d.words     = st_q.words;
         st_d.pbuf_data = `FSPS_ERASED_WORD;
         // A page write that outlives reset still needs its data; it clears at completion.
         if (wt_busy && wt_op == fsps_pkg::FSPS_OP_WRITE) begin
            st_d.loaded = st_q.loaded;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      st_q <= st_d;
   end

   fsps_wtimer #(
      .WRITE_CYCLES (WRITE_CYCLES)
   ) u_wtimer (
      .clk_in   (clk_in),
      .rstn_in  (rstn_in),
      .start_in (start_now),
      .op_in    (start_op),
      .rww_in   (start_rww),
      .busy_out (wt_busy),
      .done_out (wt_done),
      .op_out   (wt_op),
      .rww_out  (wt_rww)
   );

   assign store_enable_bit_rd = (st_q.state != fsps_pkg::FSPS_ST_IDLE) || wt_busy;
   always_comb begin
      ctl_rdata_out                                    = `FSPS_CTL_RESET;
      ctl_rdata_out[`FSPS_CTL_IRQEN]                   = st_q.irq_en;
      ctl_rdata_out[`FSPS_CTL_RWWBUSY]                 = st_q.rww_busy;
      ctl_rdata_out[`FSPS_CTL_RSVD]                    = 1'b0;
      if (st_q.state != fsps_pkg::FSPS_ST_IDLE) begin
         ctl_rdata_out[`FSPS_CTL_CMD_MSB:`FSPS_CTL_CMD_LSB] =
            st_q.cmd[`FSPS_CTL_CMD_MSB:`FSPS_CTL_CMD_LSB];
      end
      ctl_rdata_out[0]                                 = store_enable_bit_rd;
   end
   assign irq_out            = st_q.irq_en && !store_enable_bit_rd;
   assign flash_busy_out     = wt_busy;
   assign rww_read_block_out = st_q.rww_busy ||
                               (wt_busy && wt_op != fsps_pkg::FSPS_OP_LOCK);
   assign cpu_halt_out       = wt_busy && wt_op != fsps_pkg::FSPS_OP_LOCK && !wt_rww;
   assign lpm_hit_out        = st_q.lpm_hit;
   assign lpm_data_out       = st_q.lpm_data;
   assign flash_cmd_out      = st_q.fcmd;
   assign pbuf_data_out      = st_q.pbuf_data;

   default clocking @(posedge clk_in); endclocking
   default disable iff (!rstn_in);

   irq_ready_a: assert property ($fell(store_enable_bit_rd) && st_q.irq_en |-> irq_out)
      else $error("ready interrupt missing");
   window_expire_a: assert property (arm_now ##1 (!cpu_in.spm && !cpu_in.lpm &&
      !cpu_in.ctl_wr) [*4] |=> st_q.state == fsps_pkg::FSPS_ST_IDLE)
      else $error("command window did not expire");
   load_store_a: assert property (load_fire |=> st_q.loaded[$past(zword)])
      else $error("page load not stored");
   buf_clear_a: assert property (wt_done && wt_op == fsps_pkg::FSPS_OP_WRITE
      |=> st_q.loaded == '0)
      else $error("buffer not cleared after write");
   ee_discard_a: assert property (ee_busy_in |=> st_q.loaded == '0)
      else $error("buffer kept during eeprom write");
   no_readwhile_section_halt_a: assert property (wt_busy && wt_op != fsps_pkg::FSPS_OP_LOCK && !wt_rww
      |-> cpu_halt_out && rww_read_block_out)
      else $error("cpu not halted for protected section");
   rww_block_a: assert property (start_now && start_rww
      |=> (rww_read_block_out && st_q.rww_busy) [*4])
      else $error("section not blocked while busy");
   reen_clear_a: assert property (reen_fire |=> !st_q.rww_busy)
      else $error("re-enable did not clear busy flag");
   lock_read_a: assert property (wt_busy && wt_op == fsps_pkg::FSPS_OP_LOCK
      |-> !cpu_halt_out)
      else $error("cpu halted during lock programming");
   ee_refuse_a: assert property (ee_busy_in |=> !st_q.fcmd.valid && !st_q.lpm_hit)
      else $error("operation accepted during eeprom write");
   fuse_low_a: assert property (lpm_fire && cpu_in.zptr[1:0] == `FSPS_Z_FUSE_LOW
      |=> lpm_hit_out && lpm_data_out == $past(nv_in.fuse_low))
      else $error("fuse low readback wrong");
   bad_cmd_a: assert property (cpu_in.ctl_wr && st_q.state == fsps_pkg::FSPS_ST_IDLE &&
      !legal_cmd(cpu_in.ctl_wdata[`FSPS_CTL_CMD_MSB:0]) |=> st_q.state == fsps_pkg::FSPS_ST_IDLE)
      else $error("illegal command armed");
   store_enable_bit_hold_a: assert property (start_now |=> store_enable_bit_rd [*8])
      else $error("store enable dropped during operation");
endmodule

// ===== hw/fsps_regs.svh
// Constants of the flash self-programming sequencer.
`ifndef FSPS_REGS_SVH
`define FSPS_REGS_SVH
`define FSPS_CTL_IRQEN      7
`define FSPS_CTL_RWWBUSY    6
`define FSPS_CTL_RSVD       5
`define FSPS_CTL_CMD_LSB    1
`define FSPS_CTL_CMD_MSB    4
`define FSPS_CTL_RESET      8'h00
`define FSPS_CMD_LOAD       5'h01
`define FSPS_CMD_ERASE      5'h03
`define FSPS_CMD_WRITE      5'h05
`define FSPS_CMD_LOCK       5'h09
`define FSPS_CMD_REEN       5'h11
`define FSPS_SPM_WINDOW     3'h4
`define FSPS_LPM_LAST_CNT   3'h2
`define FSPS_CNT_LAST       3'h1
`define FSPS_Z_FUSE_LOW     2'h0
`define FSPS_Z_LOCK         2'h1
`define FSPS_Z_FUSE_HIGH    2'h3
`define FSPS_Z_WORD_LSB     1
`define FSPS_Z_WORD_MSB     6
`define FSPS_Z_PAGE_LSB     7
`define FSPS_Z_PAGE_MSB     13
`define FSPS_R0_BLB_LSB     2
`define FSPS_R0_BLB_MSB     5
`define FSPS_ERASED_WORD    16'hFFFF
`define FSPS_NO_FUSE        8'hFF
`define FSPS_RWW_PAGES      112
`define FSPS_CLK_PERIOD_NS  10
`define FSPS_WRITE_MIN_NS   3700000
`define FSPS_WRITE_MAX_NS   4500000
`define FSPS_WRITE_MIN_CYC  ((`FSPS_WRITE_MIN_NS + `FSPS_CLK_PERIOD_NS - 1) / `FSPS_CLK_PERIOD_NS)
`define FSPS_WRITE_MAX_CYC  (`FSPS_WRITE_MAX_NS / `FSPS_CLK_PERIOD_NS)
`define FSPS_TIMER_W        20
`endif

// ===== hw/fsps_pkg.sv
// Types of the flash self-programming sequencer.
package fsps_pkg;
   typedef enum logic [1:0] {
      FSPS_OP_NONE  = 2'h0,
      FSPS_OP_ERASE = 2'h1,
      FSPS_OP_WRITE = 2'h2,
      FSPS_OP_LOCK  = 2'h3
   } fsps_op_e;
   typedef enum logic [1:0] {
      FSPS_ST_IDLE  = 2'h0,
      FSPS_ST_ARMED = 2'h1,
      FSPS_ST_BUSY  = 2'h3
   } fsps_state_e;
   typedef struct packed {
      logic        ctl_wr;
      logic [7:0]  ctl_wdata;
      logic        spm;
      logic        lpm;
      logic [15:0] zptr;
      logic [7:0]  r1;
      logic [7:0]  r0;
   } fsps_cpu_req_t;
   typedef struct packed {
      logic [7:0] lock;
      logic [7:0] fuse_low;
      logic [7:0] fuse_high;
   } fsps_nv_t;
   typedef struct packed {
      logic       valid;
      fsps_op_e   op;
      logic [6:0] page;
      logic [3:0] lock_prog;
   } fsps_flash_cmd_t;
   typedef struct packed {
      fsps_state_e      state;
      logic [2:0]       cnt;
      logic [4:0]       cmd;
      logic             irq_en;
      logic             rww_busy;
      logic [63:0]      loaded;
      logic [63:0][15:0] words;
      logic [7:0]       lpm_data;
      logic             lpm_hit;
      fsps_flash_cmd_t  fcmd;
      logic [15:0]      pbuf_data;
   } fsps_seq_st_t;
   typedef struct packed {
      logic        busy;
      logic [19:0] cnt;
      fsps_op_e    op;
      logic        readwhile_section;
      logic        done;
   } fsps_tmr_st_t;
endpackage

// ===== hw/fsps_wtimer.sv
// Flash write timer that survives reset while an operation runs.
`include "fsps_regs.svh"
module fsps_wtimer #(
   parameter int WRITE_CYCLES = `FSPS_WRITE_MIN_CYC
) (
   input  wire logic             clk_in,
   input  wire logic             rstn_in,
   input  wire logic             start_in,
   input  fsps_pkg::fsps_op_e    op_in,
   input  wire logic             rww_in,
   output logic                  busy_out,
   output logic                  done_out,
   output fsps_pkg::fsps_op_e    op_out,
   output logic                  rww_out
);
   localparam logic [`FSPS_TIMER_W-1:0] LAST = `FSPS_TIMER_W'(WRITE_CYCLES - 1);
   if (WRITE_CYCLES < 16 || WRITE_CYCLES >= (1 << `FSPS_TIMER_W)) begin : g_bad_cycles
      $error("fsps_wtimer: WRITE_CYCLES out of range");
   end
   fsps_pkg::fsps_tmr_st_t st_q;
   fsps_pkg::fsps_tmr_st_t st_d;
   always_comb begin
      st_d      = st_q;
      st_d.done = 1'b0;
      if (st_q.busy) begin
         if (st_q.cnt == LAST) begin
            st_d.busy = 1'b0;
            st_d.done = 1'b1;
            st_d.cnt  = '0;
         end else begin
            st_d.cnt = st_q.cnt + `FSPS_TIMER_W'(1);
         end
      end else if (start_in) begin
         st_d.busy = 1'b1;
         st_d.cnt  = '0;
         st_d.op   = op_in;
         st_d.readwhile_section  = rww_in;
      end
   end
   // A running write keeps counting through reset so the array is never left half done.
   always_ff @(posedge clk_in) begin
      if (!rstn_in && st_q.busy) begin
         st_q <= st_d;
      end else if (!rstn_in) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   assign busy_out = st_q.busy;
   assign done_out = st_q.done;
   assign op_out   = st_q.op;
   assign rww_out  = st_q.readwhile_section;
   busy_hold_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      (start_in && !st_q.busy) |=> st_q.busy [*8])
      else $error("write timer ended too early");
   done_count_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      $rose(st_q.done) |-> ($past(st_q.cnt) == LAST) && !st_q.busy)
      else $error("write timer finished at wrong count");
endmodule

// ===== verif/fsps_cpu_model.sv
// CPU core model that issues control writes, store and load instructions, and EEPROM writes.
module fsps_cpu_model (
   input  wire logic               clk_in,
   input  wire logic               lpm_hit_in,
   input  wire logic [7:0]         lpm_data_in,
   output fsps_pkg::fsps_cpu_req_t cpu_out,
   output logic                    ee_busy_out,
   output logic                    got_hit_out,
   output logic [7:0]              got_data_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cpu_out = '0;
      ee_busy_out = 1'b0;
      got_hit_out = 1'b0;
      got_data_out = 8'h00;
   end
   // Kind 0 issues nothing, 1 a store, 2 a load, gap cycles after the control write.
   task automatic run(input logic [7:0] ctl, input int kind, input int gap,
                      input logic [15:0] z, input logic [15:0] d, input bit ee_mid);
      @(posedge clk_in);
      #1;
      ee_busy_out = 1'b0;
      cpu_out.ctl_wr = 1'b1;
      cpu_out.ctl_wdata = ctl;
      cpu_out.zptr = z;
      cpu_out.r1 = d[15:8];
      cpu_out.r0 = d[7:0];
      @(posedge clk_in);
      #1;
      cpu_out.ctl_wr = 1'b0;
      ee_busy_out = ee_mid;
      for (int i = 1; i < gap; i++) begin
         @(posedge clk_in);
         #1;
      end
      cpu_out.spm = (kind == 1);
      cpu_out.lpm = (kind == 2);
      @(posedge clk_in);
      #1;
      cpu_out.spm = 1'b0;
      cpu_out.lpm = 1'b0;
      got_hit_out = lpm_hit_in;
      got_data_out = lpm_data_in;
      ee_busy_out = 1'b0;
   endtask
   // Each caller loads a word once per buffer clearing and fetches nothing from the
   // busy section, so the model never exercises those illegal cases.
   task automatic ee_write(input int n);
      ee_busy_out = 1'b1;
      repeat (n) @(posedge clk_in);
      #1;
      ee_busy_out = 1'b0;
   endtask
endmodule

// ===== verif/test_fsps_sequencer.sv
// Self-checking testbench of the flash self-programming sequencer.
module test_fsps_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int WC = 32;
   logic                      clk_in;
   logic                      rstn_in;
   fsps_pkg::fsps_cpu_req_t   cpu_in;
   logic                      ee_busy_in;
   fsps_pkg::fsps_nv_t        nv_in;
   logic [5:0]                pbuf_idx_in;
   logic [7:0]                ctl_rdata_out;
   logic                      lpm_hit_out;
   logic [7:0]                lpm_data_out;
   fsps_pkg::fsps_flash_cmd_t flash_cmd_out;
   logic [15:0]               pbuf_data_out;
   logic                      flash_busy_out;
   logic                      rww_read_block_out;
   logic                      cpu_halt_out;
   logic                      irq_out;
   logic                      got_hit;
   logic [7:0]                got_data;
   fsps_pkg::fsps_flash_cmd_t c;
   int                        miscompares;
   int                        total_checks;
   int                        n;
   logic [15:0]               zs [3];
   logic [7:0]                ex [3];
   fsps_sequencer #(.RWW_PAGES(112), .WRITE_CYCLES(WC)) fsps_sequencer_inst (
      .clk_in(clk_in), .rstn_in(rstn_in), .cpu_in(cpu_in), .ee_busy_in(ee_busy_in),
      .nv_in(nv_in), .pbuf_idx_in(pbuf_idx_in), .ctl_rdata_out(ctl_rdata_out),
      .lpm_hit_out(lpm_hit_out), .lpm_data_out(lpm_data_out), .flash_cmd_out(flash_cmd_out),
      .pbuf_data_out(pbuf_data_out), .flash_busy_out(flash_busy_out),
      .rww_read_block_out(rww_read_block_out), .cpu_halt_out(cpu_halt_out), .irq_out(irq_out));
   fsps_cpu_model fsps_cpu_model_inst (
      .clk_in(clk_in), .lpm_hit_in(lpm_hit_out), .lpm_data_in(lpm_data_out),
      .cpu_out(cpu_in), .ee_busy_out(ee_busy_in), .got_hit_out(got_hit),
      .got_data_out(got_data));
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic logic [15:0] zp(input int page, input int word);
      return {2'b00, 7'(page), 6'(word), 1'b0};
   endfunction
   task automatic rd_buf(input logic [5:0] idx, input logic [15:0] exp);
      pbuf_idx_in = idx;
      @(posedge clk_in);
      #1;
      chk(pbuf_data_out, exp);
   endtask
   task automatic rst(input int cycles);
      rstn_in = 1'b0;
      repeat (cycles) @(posedge clk_in);
      #1 rstn_in = 1'b1;
   endtask
   // The command pulse is looked for over a few cycles, so its latency is not pinned here.
   task automatic wait_cmd();
      c = '0;
      repeat (4) begin
         if (flash_cmd_out.valid === 1'b1 && c.valid !== 1'b1) c = flash_cmd_out;
         if (c.valid !== 1'b1) begin
            @(posedge clk_in);
            #1;
         end
      end
      chk(c.valid, 1'b1);
   endtask
   task automatic wait_idle();
      n = 0;
      while (flash_busy_out === 1'b1 && n < 1000) begin
         @(posedge clk_in);
         #1;
         n++;
      end
      // The sequencer leaves its busy state one cycle after the timer, so let that edge pass.
      @(posedge clk_in);
      #1;
      if (n >= 1000) begin
         miscompares++;
         give_verdict();
      end
   endtask
   initial begin
      miscompares = 0;
      total_checks = 0;
      rstn_in = 1'b0;
      pbuf_idx_in = 6'h00;
      nv_in = {8'hE5, 8'h5A, 8'hC9};
      zs = '{16'h0001, 16'h0000, 16'h0003};
      ex = '{8'hE5, 8'h5A, 8'hC9};
      repeat (4) @(posedge clk_in);
      #1 rstn_in = 1'b1;
      chk(ctl_rdata_out, 8'h00);
      rd_buf(6'h05, 16'hFFFF);
      fsps_cpu_model_inst.run(8'h01, 1, 4, zp(0, 5), 16'h1234, 1'b0);
      rd_buf(6'h05, 16'h1234);
      fsps_cpu_model_inst.run(8'h01, 1, 5, zp(0, 6), 16'hABCD, 1'b0);
      rd_buf(6'h06, 16'hFFFF);
      fsps_cpu_model_inst.run(8'h07, 0, 1, 16'h0000, 16'h0000, 1'b0);
      chk(ctl_rdata_out[4:0], 5'h00);
      fsps_cpu_model_inst.run(8'h80, 0, 1, 16'h0000, 16'h0000, 1'b0);
      chk(ctl_rdata_out, 8'h80);
      chk(irq_out, 1'b1);
      fsps_cpu_model_inst.run(8'h81, 0, 2, 16'h0000, 16'h0000, 1'b0);
      chk(irq_out, 1'b0);
      repeat (4) @(posedge clk_in);
      #1;
      chk(ctl_rdata_out, 8'h80);
      chk(irq_out, 1'b1);
      fsps_cpu_model_inst.run(8'h05, 1, 1, zp(3, 0), 16'h0000, 1'b0);
      wait_cmd();
      chk(c.op, fsps_pkg::FSPS_OP_WRITE);
      chk(c.page, 7'd3);
      @(posedge clk_in);
      #1;
      chk(ctl_rdata_out[6], 1'b1);
      chk(ctl_rdata_out[0], 1'b1);
      chk(rww_read_block_out, 1'b1);
      chk(cpu_halt_out, 1'b0);
      wait_idle();
      chk(n >= WC - 2 && n <= WC + 1, 1'b1);
      chk(ctl_rdata_out[0], 1'b0);
      chk(ctl_rdata_out[6], 1'b1);
      rd_buf(6'h05, 16'hFFFF);
      fsps_cpu_model_inst.run(8'h11, 1, 1, 16'h0000, 16'h0000, 1'b0);
      chk(ctl_rdata_out[6], 1'b0);
      chk(rww_read_block_out, 1'b0);
      fsps_cpu_model_inst.run(8'h01, 1, 2, zp(0, 8), 16'h5555, 1'b0);
      fsps_cpu_model_inst.run(8'h11, 1, 1, 16'h0000, 16'h0000, 1'b0);
      rd_buf(6'h08, 16'hFFFF);
      fsps_cpu_model_inst.run(8'h05, 1, 2, zp(120, 0), 16'h0000, 1'b0);
      wait_cmd();
      @(posedge clk_in);
      #1;
      chk(cpu_halt_out, 1'b1);
      rst(2);
      chk(flash_busy_out, 1'b1);
      chk(ctl_rdata_out[0], 1'b1);
      wait_idle();
      chk(cpu_halt_out, 1'b0);
      fsps_cpu_model_inst.run(8'h03, 1, 3, zp(2, 0), 16'h0000, 1'b0);
      wait_cmd();
      chk(c.op, fsps_pkg::FSPS_OP_ERASE);
      chk(c.page, 7'd2);
      @(posedge clk_in);
      #1;
      chk(rww_read_block_out, 1'b1);
      wait_idle();
      fsps_cpu_model_inst.run(8'h11, 1, 1, 16'h0000, 16'h0000, 1'b0);
      chk(ctl_rdata_out[6], 1'b0);
      fsps_cpu_model_inst.run(8'h09, 1, 4, 16'h0001, 16'hFFD7, 1'b0);
      wait_cmd();
      chk(c.op, fsps_pkg::FSPS_OP_LOCK);
      chk(c.lock_prog, 4'hA);
      @(posedge clk_in);
      #1;
      chk({rww_read_block_out, cpu_halt_out}, 2'b00);
      wait_idle();
      chk(n >= WC - 2 && n <= WC + 1, 1'b1);
      for (int i = 0; i < 3; i++) begin
         fsps_cpu_model_inst.run(8'h09, 2, 3, zs[i], 16'h0000, 1'b0);
         chk(got_hit, 1'b1);
         chk(got_data, ex[i]);
         chk(ctl_rdata_out[3:0], 4'h0);
      end
      fsps_cpu_model_inst.run(8'h09, 2, 4, 16'h0001, 16'h0000, 1'b0);
      chk(got_hit, 1'b0);
      fsps_cpu_model_inst.run(8'h09, 2, 1, 16'h0001, 16'h0000, 1'b1);
      chk(got_hit, 1'b0);
      fsps_cpu_model_inst.run(8'h05, 1, 1, zp(4, 0), 16'h0000, 1'b1);
      repeat (3) @(posedge clk_in);
      #1;
      chk(flash_busy_out, 1'b0);
      fsps_cpu_model_inst.run(8'h01, 1, 1, zp(0, 7), 16'h7777, 1'b0);
      rd_buf(6'h07, 16'h7777);
      fsps_cpu_model_inst.ee_write(2);
      rd_buf(6'h07, 16'hFFFF);
      fsps_cpu_model_inst.run(8'h01, 1, 1, zp(0, 9), 16'h9999, 1'b0);
      rst(2);
      rd_buf(6'h09, 16'hFFFF);
      chk(ctl_rdata_out, 8'h00);
      give_verdict();
   end
endmodule
